// ### pcs_an_pkg.sv
package pcs_an_pkg;

  // ==========================================================
  // timing at the 20 MHz core clock
  localparam int unsigned CLK_PERIOD_NS        = 50;
  localparam int unsigned LINK_TIMER_BASEX_NS  = 10_000_000; // 10 ms
  localparam int unsigned LINK_TIMER_SGMII_NS  = 1_600_000;  // 1.6 ms
  localparam int unsigned LINK_TIMER_BASEX_CYC = LINK_TIMER_BASEX_NS / CLK_PERIOD_NS;
  localparam int unsigned LINK_TIMER_SGMII_CYC = LINK_TIMER_SGMII_NS / CLK_PERIOD_NS;
  localparam int unsigned TIMER_W              = 18;
  localparam int unsigned MATCH_NEEDED         = 3;

  // ==========================================================
  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_CTRL      = 8'h00;
  localparam logic [7:0] IDX_STATUS    = 8'h01;
  localparam logic [7:0] IDX_ADVERT    = 8'h04;
  localparam logic [7:0] IDX_PARTNER   = 8'h05;
  localparam logic [7:0] IDX_IRQ_CTRL  = 8'h10;
  localparam logic [7:0] IDX_EVT_STAT  = 8'h12;
  localparam logic [7:0] IDX_EVT_MASK  = 8'h13;

  // ==========================================================
  // field positions
  localparam int unsigned CTRL_SGMII_BIT    = 0;
  localparam int unsigned CTRL_PHY_BIT      = 1;
  localparam int unsigned CTRL_2G5_BIT      = 2;
  localparam int unsigned CTRL_RESTART_BIT  = 9;
  localparam int unsigned CTRL_AN_EN_BIT    = 12;
  localparam int unsigned STAT_LINK_BIT     = 2;
  localparam int unsigned STAT_ABLE_BIT     = 3;
  localparam int unsigned STAT_DONE_BIT     = 5;
  localparam int unsigned IRQC_EN_BIT       = 0;
  localparam int unsigned IRQC_STAT_BIT     = 1;
  localparam int unsigned WORD_ACK_BIT      = 14;
  localparam int unsigned EVT_W             = 4;

  // ==========================================================
  // reset values and fixed words
  localparam logic [15:0] ADVERT_RESET      = 16'h0020;
  localparam logic [15:0] SGMII_MAC_WORD    = 16'h4001;
  localparam logic [1:0]  SPEED_1G          = 2'h2;
  localparam logic [2:0]  EBUF_UNDERFLOW    = 3'h5;
  localparam logic [2:0]  EBUF_OVERFLOW     = 3'h6;
  localparam logic [1:0]  RESP_OKAY         = 2'h0;
  localparam logic [1:0]  RESP_SLVERR       = 2'h2;

  typedef enum logic [2:0] {
    ST_DISABLED = 3'h0,
    ST_RESTART  = 3'h1,
    ST_ABILITY  = 3'h2,
    ST_ACK      = 3'h3,
    ST_COMPLETE = 3'h4,
    ST_IDLE_DET = 3'h5,
    ST_LINK_OK  = 3'h6
  } an_state_t;

endpackage : pcs_an_pkg

// ### pcs_auto_negotiation.sv
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module pcs_auto_negotiation #(
  parameter int unsigned LINK_TIMER_BASEX = pcs_an_pkg::LINK_TIMER_BASEX_CYC,
  parameter int unsigned LINK_TIMER_SGMII = pcs_an_pkg::LINK_TIMER_SGMII_CYC
) (
  input  wire logic        core_clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        ce_i,
  input  wire logic [9:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [9:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  input  wire logic        sync_ok_i,
  input  wire logic        rx_cfg_valid_i,
  input  wire logic [15:0] rx_cfg_word_i,
  input  wire logic        rx_idle_i,
  input  wire logic [2:0]  clk_cor_count_i,
  input  wire logic [2:0]  elastic_buf_state_i,
  input  wire logic        negotiation_restart_request_i,
  input  wire logic [15:0] advert_config_bus_i,
  input  wire logic        advert_config_qualifier_i,
  output logic             tx_cfg_send_o,
  output logic [15:0]      tx_cfg_word_o,
  output logic [7:0]       status_bus_o,
  output logic             negotiation_done_irq_o,
  output logic             event_irq_o
);

  // ==========================================================
  // negotiation state
  pcs_an_pkg::an_state_t         state, next_state;
  logic [pcs_an_pkg::TIMER_W-1:0] tmr, next_tmr, tmr_end, next_tmr_end;
  logic [1:0]                    match_cnt, next_match_cnt;
  logic [15:0]                   last_word, next_last_word;
  logic [15:0]                   partner, next_partner;
  logic                          done_flag, next_done_flag;
  logic                          restart_pin_d, next_restart_pin_d;
  logic                          start_tmr, tmr_done, good_word, buf_err, frag;
  logic                          restart_req, an_restart_evt, an_done_evt;

  // ==========================================================
  // register and bus state
  logic [15:0]                   ctrl, next_ctrl, advert, next_advert;
  logic [1:0]                    irq_ctrl, next_irq_ctrl;
  logic [pcs_an_pkg::EVT_W-1:0]  evt_stat, next_evt_stat, evt_mask, next_evt_mask;
  logic                          aw_have, next_aw_have, w_have, next_w_have;
  logic [7:0]                    aw_idx, next_aw_idx;
  logic [31:0]                   w_data, next_w_data;
  logic [3:0]                    w_strb, next_w_strb;
  logic                          bvalid, next_bvalid, rvalid, next_rvalid;
  logic [1:0]                    bresp, next_bresp, rresp, next_rresp;
  logic [31:0]                   rdata, next_rdata;
  logic                          wr_fire, rd_fire;
  logic [7:0]                    ar_idx;
  logic [15:0]                   tx_word, status_word;
  logic [pcs_an_pkg::EVT_W-1:0]  evt_set;

  // fragments and elastic buffer errors make a word untrustworthy
  assign frag      = rx_cfg_valid_i && (clk_cor_count_i != 3'h0);
  assign buf_err   = (elastic_buf_state_i == pcs_an_pkg::EBUF_UNDERFLOW) ||
                     (elastic_buf_state_i == pcs_an_pkg::EBUF_OVERFLOW);
  assign good_word = rx_cfg_valid_i && !frag && !buf_err;
  assign tmr_done  = (tmr >= tmr_end);
  assign restart_req = ctrl[pcs_an_pkg::CTRL_RESTART_BIT] ||
                       (negotiation_restart_request_i && !restart_pin_d);

  // outgoing word: fixed in SGMII MAC mode, advertisement with speed forced to 1G in SGMII PHY 2.5G mode, else advertisement register
  always_comb
  begin
    tx_word = advert;
    if (ctrl[pcs_an_pkg::CTRL_SGMII_BIT] && !ctrl[pcs_an_pkg::CTRL_PHY_BIT])
      tx_word = pcs_an_pkg::SGMII_MAC_WORD;
    else if (ctrl[pcs_an_pkg::CTRL_SGMII_BIT] && ctrl[pcs_an_pkg::CTRL_2G5_BIT])
      tx_word[11:10] = pcs_an_pkg::SPEED_1G;
  end

  // negotiation next state
  always_comb
  begin
    next_state         = state;
    next_match_cnt     = match_cnt;
    next_last_word     = last_word;
    next_partner       = partner;
    next_done_flag     = done_flag;
    next_restart_pin_d = negotiation_restart_request_i;
    start_tmr          = 1'b0;
    an_done_evt        = 1'b0;
    an_restart_evt     = 1'b0;
    unique case (state)
      pcs_an_pkg::ST_DISABLED: ;
      pcs_an_pkg::ST_RESTART:
        if (tmr_done)
          next_state = pcs_an_pkg::ST_ABILITY;
      pcs_an_pkg::ST_ABILITY:
        if (good_word && rx_cfg_word_i != 16'h0000)
        begin
          // three matching words, ack bit ignored, settle the partner
          if ((rx_cfg_word_i & ~16'h4000) == (last_word & ~16'h4000))
            next_match_cnt = match_cnt + 2'h1;
          else
            next_match_cnt = 2'h1;
          next_last_word = rx_cfg_word_i;
          next_partner   = rx_cfg_word_i;
          if (32'(next_match_cnt) >= pcs_an_pkg::MATCH_NEEDED)
            next_state = pcs_an_pkg::ST_ACK;
        end
      pcs_an_pkg::ST_ACK:
        if (good_word && rx_cfg_word_i[pcs_an_pkg::WORD_ACK_BIT])
        begin
          next_state = pcs_an_pkg::ST_COMPLETE;
          start_tmr  = 1'b1;
        end
      pcs_an_pkg::ST_COMPLETE:
        if (tmr_done)
        begin
          next_state = pcs_an_pkg::ST_IDLE_DET;
          start_tmr  = 1'b1;
        end
      pcs_an_pkg::ST_IDLE_DET:
        if (tmr_done && rx_idle_i)
        begin
          next_state     = pcs_an_pkg::ST_LINK_OK;
          next_done_flag = 1'b1;
          an_done_evt    = 1'b1;
        end
      pcs_an_pkg::ST_LINK_OK:
        if (good_word)
          next_state = pcs_an_pkg::ST_ABILITY;
      default:
        next_state = pcs_an_pkg::ST_RESTART;
    endcase
    // disabled at both ends: no words are sent, link follows sync
    if (!ctrl[pcs_an_pkg::CTRL_AN_EN_BIT])
    begin
      next_state     = pcs_an_pkg::ST_DISABLED;
      next_done_flag = 1'b0;
    end
    else if (!sync_ok_i || restart_req || state == pcs_an_pkg::ST_DISABLED)
    begin
      next_state     = pcs_an_pkg::ST_RESTART;
      next_done_flag = 1'b0;
      start_tmr      = 1'b1;
      an_restart_evt = 1'b1;
    end
    if (next_state == pcs_an_pkg::ST_ABILITY && state != pcs_an_pkg::ST_ABILITY)
      next_match_cnt = 2'h0;
    // terminal count chosen at start, a mode change mid-cycle waits
    next_tmr_end = tmr_end;
    next_tmr     = tmr_done ? tmr : tmr + 1'b1;
    if (start_tmr)
    begin
      next_tmr     = '0;
      next_tmr_end = ctrl[pcs_an_pkg::CTRL_SGMII_BIT] ? LINK_TIMER_SGMII[pcs_an_pkg::TIMER_W-1:0]
                                                      : LINK_TIMER_BASEX[pcs_an_pkg::TIMER_W-1:0];
    end
  end

  // status word, events and bus decode
  always_comb
  begin
    status_word = '0;
    status_word[pcs_an_pkg::STAT_DONE_BIT] = done_flag;
    status_word[pcs_an_pkg::STAT_ABLE_BIT] = 1'b1;
    status_word[pcs_an_pkg::STAT_LINK_BIT] = sync_ok_i &&
      (state == pcs_an_pkg::ST_LINK_OK || state == pcs_an_pkg::ST_DISABLED);
    evt_set = {frag, buf_err && rx_cfg_valid_i, an_restart_evt, an_done_evt};
    wr_fire = aw_have && w_have && !bvalid;
    ar_idx  = s_axi_araddr_i[9:2];
    rd_fire = s_axi_arvalid_i && s_axi_arready_o;                          // take only while ready shows
  end

  // register file next state
  always_comb
  begin
    next_ctrl     = ctrl;
    next_ctrl[pcs_an_pkg::CTRL_RESTART_BIT] = 1'b0;                        // self-clearing
    next_advert   = advert;
    next_irq_ctrl = irq_ctrl;
    next_evt_mask = evt_mask;
    next_evt_stat = evt_stat;
    // a channel is taken only at an edge where its ready output is high
    next_aw_have  = aw_have || (s_axi_awvalid_i && s_axi_awready_o);
    next_aw_idx   = (s_axi_awready_o && s_axi_awvalid_i) ? s_axi_awaddr_i[9:2] : aw_idx;
    next_w_have   = w_have || (s_axi_wvalid_i && s_axi_wready_o);
    next_w_data   = (s_axi_wready_o && s_axi_wvalid_i) ? s_axi_wdata_i : w_data;
    next_w_strb   = (s_axi_wready_o && s_axi_wvalid_i) ? s_axi_wstrb_i : w_strb;
    next_bvalid   = bvalid && !s_axi_bready_i;
    next_bresp    = bresp;
    next_rvalid   = rvalid && !s_axi_rready_i;
    next_rresp    = rresp;
    next_rdata    = rdata;
    if (advert_config_qualifier_i)
      next_advert = advert_config_bus_i;
    if (wr_fire)
    begin
      next_aw_have = 1'b0;
      next_w_have  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = pcs_an_pkg::RESP_OKAY;
      unique case (aw_idx)
        pcs_an_pkg::IDX_CTRL:
        begin
          if (w_strb[0]) next_ctrl[7:0]  = w_data[7:0];
          if (w_strb[1]) next_ctrl[15:8] = w_data[15:8];
        end
        pcs_an_pkg::IDX_ADVERT:
        begin
          if (w_strb[0]) next_advert[7:0]  = w_data[7:0];
          if (w_strb[1]) next_advert[15:8] = w_data[15:8];
        end
        pcs_an_pkg::IDX_IRQ_CTRL:
          if (w_strb[0]) next_irq_ctrl = w_data[1:0] & irq_ctrl | {1'b0, w_data[0]};
        pcs_an_pkg::IDX_EVT_MASK:
          if (w_strb[0]) next_evt_mask = w_data[pcs_an_pkg::EVT_W-1:0];
        pcs_an_pkg::IDX_STATUS, pcs_an_pkg::IDX_PARTNER, pcs_an_pkg::IDX_EVT_STAT: ;
        default:
          next_bresp = pcs_an_pkg::RESP_SLVERR;
      endcase
    end
    if (rd_fire)
    begin
      next_rvalid = 1'b1;
      next_rresp  = pcs_an_pkg::RESP_OKAY;
      next_rdata  = '0;
      unique case (ar_idx)
        pcs_an_pkg::IDX_CTRL:     next_rdata[15:0] = ctrl;
        pcs_an_pkg::IDX_STATUS:   next_rdata[15:0] = status_word;
        pcs_an_pkg::IDX_ADVERT:   next_rdata[15:0] = advert;
        pcs_an_pkg::IDX_PARTNER:  next_rdata[15:0] = partner;
        pcs_an_pkg::IDX_IRQ_CTRL: next_rdata[1:0]  = irq_ctrl;
        pcs_an_pkg::IDX_EVT_MASK: next_rdata[pcs_an_pkg::EVT_W-1:0] = evt_mask;
        pcs_an_pkg::IDX_EVT_STAT:
        begin
          next_rdata[pcs_an_pkg::EVT_W-1:0] = evt_stat;
          next_evt_stat = '0;                                              // read clears
        end
        default:
          next_rresp = pcs_an_pkg::RESP_SLVERR;
      endcase
    end
    // hardware sets win over clears
    next_evt_stat = next_evt_stat | evt_set;
    if (an_done_evt && irq_ctrl[pcs_an_pkg::IRQC_EN_BIT])
      next_irq_ctrl[pcs_an_pkg::IRQC_STAT_BIT] = 1'b1;
  end

  // negotiation registers
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state         <= pcs_an_pkg::ST_RESTART;
      tmr           <= '0;
      tmr_end       <= LINK_TIMER_BASEX[pcs_an_pkg::TIMER_W-1:0];
      match_cnt     <= 2'h0;
      last_word     <= 16'h0000;
      partner       <= 16'h0000;
      done_flag     <= 1'b0;
      restart_pin_d <= 1'b0;
    end
    else if (ce_i)
    begin
      state         <= next_state;
      tmr           <= next_tmr;
      tmr_end       <= next_tmr_end;
      match_cnt     <= next_match_cnt;
      last_word     <= next_last_word;
      partner       <= next_partner;
      done_flag     <= next_done_flag;
      restart_pin_d <= next_restart_pin_d;
    end
  end

  // register file, bus and output flops
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ctrl <= 16'h1000;
      advert <= pcs_an_pkg::ADVERT_RESET;
      irq_ctrl <= 2'h0;
      evt_stat <= '0;
      evt_mask <= '0;
      aw_have <= 1'b0;
      aw_idx <= 8'h00;
      w_have <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
      rvalid <= 1'b0;
      rresp <= 2'h0;
      rdata <= 32'h0000_0000;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o <= 1'b0;
      s_axi_arready_o <= 1'b0;
      tx_cfg_send_o <= 1'b0;
      tx_cfg_word_o <= 16'h0000;
      status_bus_o <= 8'h00;
      negotiation_done_irq_o <= 1'b0;
      event_irq_o <= 1'b0;
    end
    else if (ce_i)
    begin
      ctrl <= next_ctrl;
      advert <= next_advert;
      irq_ctrl <= next_irq_ctrl;
      evt_stat <= next_evt_stat;
      evt_mask <= next_evt_mask;
      aw_have <= next_aw_have;
      aw_idx <= next_aw_idx;
      w_have <= next_w_have;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
      s_axi_awready_o <= !next_aw_have;
      s_axi_wready_o <= !next_w_have;
      s_axi_arready_o <= !next_rvalid;
      // words go out from restart through complete, zero during restart
      tx_cfg_send_o <= next_state inside {pcs_an_pkg::ST_RESTART, pcs_an_pkg::ST_ABILITY,
                                          pcs_an_pkg::ST_ACK, pcs_an_pkg::ST_COMPLETE};
      tx_cfg_word_o <= (next_state == pcs_an_pkg::ST_RESTART) ? 16'h0000 :
                       (next_state == pcs_an_pkg::ST_ABILITY) ? tx_word :
                       (tx_word | 16'h4000);
      // done, pause, fault, speed, duplex of the partner
      status_bus_o <= {next_partner[12], next_partner[11:10], next_partner[13:12] & {2{!ctrl[0]}},
                       next_partner[8:7], next_done_flag};
      negotiation_done_irq_o <= next_irq_ctrl[pcs_an_pkg::IRQC_EN_BIT] &&
                                next_irq_ctrl[pcs_an_pkg::IRQC_STAT_BIT];
      event_irq_o <= |(next_evt_stat & next_evt_mask);
    end
  end

  assign s_axi_bvalid_o = bvalid;
  assign s_axi_bresp_o  = bresp;
  assign s_axi_rvalid_o = rvalid;
  assign s_axi_rresp_o  = rresp;
  assign s_axi_rdata_o  = rdata;

  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);

  chk_sync_loss_restart: assert property (ce_i && ctrl[12] && !sync_ok_i |=> state == pcs_an_pkg::ST_RESTART)
    else $error("sync loss did not restart");
  chk_done_flag_set: assert property (ce_i && an_done_evt |=> done_flag && status_bus_o[0])
    else $error("completion flag not set");
  chk_irq_off_low: assert property (!irq_ctrl[0] |-> ##1 !negotiation_done_irq_o || $past(!ce_i))
    else $error("irq high while disabled");
  chk_irq_after_done: assert property (ce_i && an_done_evt && irq_ctrl[0] |=> negotiation_done_irq_o)
    else $error("irq missed completion");
  chk_frag_ignored: assert property (ce_i && frag && state == pcs_an_pkg::ST_ABILITY |=> $stable(match_cnt))
    else $error("fragment counted");
  chk_buferr_ignored: assert property (ce_i && buf_err && state == pcs_an_pkg::ST_ACK && sync_ok_i
                                       && !restart_req && ctrl[12] |=> state == pcs_an_pkg::ST_ACK)
    else $error("buffer error advanced");
  chk_timer_bound: assert property (tmr <= tmr_end || start_tmr)
    else $error("link timer overran");
  chk_disabled_quiet: assert property (ce_i && !ctrl[12] |=> ##1 !tx_cfg_send_o || $past(!ce_i))
    else $error("words sent while disabled");
  chk_advert_bus: assert property (ce_i && advert_config_qualifier_i && !wr_fire
                                   |=> advert == $past(advert_config_bus_i))
    else $error("advertisement bus not taken");

  cov_done: cover property (an_done_evt);
  cov_restart_pin: cover property (negotiation_restart_request_i && !restart_pin_d && ce_i);
  cov_frag: cover property (frag && state == pcs_an_pkg::ST_ABILITY);
  cov_evt_read: cover property (rd_fire && ar_idx == pcs_an_pkg::IDX_EVT_STAT && evt_stat != '0);

endmodule : pcs_auto_negotiation

`default_nettype wire

// ### pcs_an_partner.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// far end link partner
module pcs_an_partner (
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        send_i,
  input  wire logic [15:0] word_i,
  input  wire logic [15:0] adv_i,
  input  wire logic [1:0]  err_i,
  output logic             cfg_valid_o,
  output logic [15:0]      cfg_word_o,
  output logic             idle_o,
  output logic [2:0]       cor_cnt_o,
  output logic [2:0]       buf_state_o
);
  logic [1:0] seen;
  logic       odd;
  logic       bad;
  // every other word is spoilt while an error mode is asked for
  assign bad = send_i && odd && err_i != 2'h0;
  // mirror the far end, ack after three of its words
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      {cfg_valid_o, cfg_word_o, cor_cnt_o, buf_state_o, seen, odd} <= '0;
      idle_o <= 1'b1;
    end
    else
    begin
      seen        <= (send_i && word_i != 16'h0000) ? seen + 2'(seen != 2'h3) : 2'h0;
      odd         <= !odd;
      cfg_valid_o <= send_i;
      idle_o      <= !send_i;
      cor_cnt_o   <= (bad && err_i == 2'h1) ? 3'h1 : 3'h0;
      buf_state_o <= !(bad && err_i[1]) ? 3'h0 : err_i[0] ? pcs_an_pkg::EBUF_OVERFLOW : pcs_an_pkg::EBUF_UNDERFLOW;
      // released line inverts its word every cycle
      cfg_word_o  <= !send_i ? ~cfg_word_o : bad ? ~adv_i : adv_i | {1'b0, seen == 2'h3, 14'h0000};
    end
  end
endmodule : pcs_an_partner
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// bench top
module tb_top;
  typedef struct {logic w; logic [7:0] i; logic [15:0] d; logic [15:0] e; logic [1:0] r;} row_t;
  typedef struct {logic [15:0] ctrl; logic [15:0] adv; logic [15:0] tx; int t;} mode_t;
  row_t rows[8] = '{'{1'b0, 8'h00, 16'h0000, 16'h1000, 2'h0}, '{1'b0, 8'h04, 16'h0000, 16'h0020, 2'h0},
    '{1'b1, 8'h04, 16'h01A0, 16'h0000, 2'h0}, '{1'b0, 8'h04, 16'h0000, 16'h01A0, 2'h0},
    '{1'b0, 8'h10, 16'h0000, 16'h0000, 2'h0}, '{1'b1, 8'h07, 16'h0001, 16'h0000, 2'h2},
    '{1'b0, 8'h07, 16'h0000, 16'h0000, 2'h2}, '{1'b1, 8'h05, 16'hFFFF, 16'h0000, 2'h0}};
  mode_t modes[5] = '{'{16'h1000, 16'h01A0, 16'h01A0, 20}, '{16'h1001, 16'h01A0, 16'h0001, 8},
    '{16'h1005, 16'h01A0, 16'h0001, 8}, '{16'h1003, 16'h9801, 16'h9801, 8}, '{16'h1007, 16'h9401, 16'h9801, 8}};
  logic        clk = 0, rst_n = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, sync_ok = 1, pin = 0, qual = 0;
  logic [9:0]  awa = '0, ara = '0;
  logic [31:0] wd = '0, rd, rdat;
  logic [15:0] abus = '0, padv = 16'h2D80, txw, cw;
  logic [1:0]  err = '0, rsp, br, rr;
  logic        awr, wrdy, bv, arr, rv, snd, cv, idl, irq, eirq;
  logic [7:0]  sb;
  logic [2:0]  cc, bs;
  int          bad_count = 0, check_count = 0, cyc = 0, n;
  initial forever #25 clk = ~clk;
  pcs_auto_negotiation #(.LINK_TIMER_BASEX(20), .LINK_TIMER_SGMII(8)) dut (.core_clk_i(clk), .arst_n_i(rst_n),
    .ce_i(1'b1), .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd),
    .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrdy), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv),
    .s_axi_bready_i(bry), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
    .s_axi_rdata_o(rdat), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(rry), .sync_ok_i(sync_ok),
    .rx_cfg_valid_i(cv), .rx_cfg_word_i(cw), .rx_idle_i(idl), .clk_cor_count_i(cc), .elastic_buf_state_i(bs),
    .negotiation_restart_request_i(pin), .advert_config_bus_i(abus), .advert_config_qualifier_i(qual),
    .tx_cfg_send_o(snd), .tx_cfg_word_o(txw), .status_bus_o(sb), .negotiation_done_irq_o(irq), .event_irq_o(eirq));
  pcs_an_partner peer (.clk_i(clk), .arst_n_i(rst_n), .send_i(snd), .word_i(txw), .adv_i(padv), .err_i(err),
    .cfg_valid_o(cv), .cfg_word_o(cw), .idle_o(idl), .cor_cnt_o(cc), .buf_state_o(bs));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) $display("CHECK FAILED at %0t: saw %h want %h", $time, s, e);
    if (s !== e) bad_count++;
  endtask : chk
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  // one register access, write or read, each channel released when taken
  task automatic ax(input logic w, input logic [7:0] i, input logic [15:0] d);
    logic dn;
    dn = 0;
    awa <= {i, 2'b00};
    ara <= {i, 2'b00};
    wd <= 32'(d);
    {awv, wv, bry} <= {3{w}};
    {arv, rry} <= {2{!w}};
    while (!dn)
    begin
      @(posedge clk);
      if (awv && awr) awv <= 0;
      if (wv && wrdy) wv <= 0;
      if (arv && arr) arv <= 0;
      dn = (bry && bv) || (rry && rv);
      rsp = w ? br : rr;
      rd = rdat;
    end
    {bry, rry} <= 2'b00;
    @(posedge clk);
  endtask : ax
  // wait for completion, counting cycles
  task automatic wdone(output int c);
    c = 0;
    while (sb[0] !== 1'b1 && c < 2000)
    begin
      @(posedge clk);
      c++;
    end
    chk(32'(sb[0]), 1);
  endtask : wdone
  task automatic pulse();
    pin <= 1;
    @(posedge clk);
    pin <= 0;
    repeat (4) @(posedge clk);
    chk(32'(sb[0]), 0);
  endtask : pulse
  // hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000) bad_count++;
    if (cyc == 30000) final_report();
  end
  // main sequence
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1;
    repeat (2) @(posedge clk);
    wdone(n);
    foreach (rows[k])
    begin
      ax(rows[k].w, rows[k].i, rows[k].d);
      chk(32'(rsp), 32'(rows[k].r));
      if (!rows[k].w) chk(rd, 32'(rows[k].e));
    end
    foreach (modes[k])
    begin
      ax(1, pcs_an_pkg::IDX_ADVERT, modes[k].adv);
      ax(1, pcs_an_pkg::IDX_CTRL, modes[k].ctrl | 16'h0200);
      for (n = 0; !(snd === 1'b1 && txw !== 16'h0000) && n < 500; n++) @(posedge clk);
      chk(32'(txw & 16'hBFFF), 32'(modes[k].tx));
      wdone(n);
      chk(32'(n >= 2 * modes[k].t && n < 2 * modes[k].t + 20), 1);
      chk(32'(sb), 32'({padv[12], padv[11:10], modes[k].ctrl[0] ? 2'b00 : padv[13:12], padv[8:7], 1'b1}));
      ax(0, pcs_an_pkg::IDX_PARTNER, 16'h0000);
      chk(rd & 32'hBFFF, 32'(padv));
      ax(0, pcs_an_pkg::IDX_STATUS, 16'h0000);
      chk(32'(rd[5]), 1);
    end
    ax(1, pcs_an_pkg::IDX_IRQ_CTRL, 16'h0001);
    ax(1, pcs_an_pkg::IDX_EVT_MASK, 16'h0001);
    ax(0, pcs_an_pkg::IDX_EVT_STAT, 16'h0000);
    pulse();
    wdone(n);
    chk(32'({irq, eirq}), 3);
    ax(0, pcs_an_pkg::IDX_EVT_STAT, 16'h0000);
    chk(rd & 32'h1, 1);
    ax(1, pcs_an_pkg::IDX_IRQ_CTRL, 16'h0003);
    chk(32'({irq, eirq}), 2);
    ax(1, pcs_an_pkg::IDX_IRQ_CTRL, 16'h0001);
    @(posedge clk);
    chk(32'(irq), 0);
    ax(1, pcs_an_pkg::IDX_IRQ_CTRL, 16'h0000);
    pulse();
    wdone(n);
    ax(0, pcs_an_pkg::IDX_IRQ_CTRL, 16'h0000);
    chk({rd[31:1], irq}, 0);
    for (int e = 1; e < 4; e++)
    begin
      err <= 2'(e);
      pulse();
      wdone(n);
    end
    err <= 2'h0;
    sync_ok <= 0;
    repeat (4) @(posedge clk);
    chk(32'(sb[0]), 0);
    sync_ok <= 1;
    wdone(n);
    abus <= 16'h0120;
    qual <= 1;
    repeat (2) @(posedge clk);
    ax(0, pcs_an_pkg::IDX_ADVERT, 16'h0000);
    chk(rd, 32'h0120);
    qual <= 0;
    final_report();
  end
endmodule : tb_top
`default_nettype wire
